/* rtl/aam_defs.svh */
// ============================================================
// constants for the protection alarm monitor: protection byte field
// positions, request and mode codes, and frame counts for stability
// assumes: included by bare name from the package and the design files
`ifndef AAM_DEFS_SVH
`define AAM_DEFS_SVH

// ============================================================
// protection byte fields
`define AAM_K1_REQ_HI 7
`define AAM_K1_REQ_LO 4
`define AAM_K1_CHAN_HI 3
`define AAM_K1_CHAN_LO 0
`define AAM_K2_CHAN_HI 7
`define AAM_K2_CHAN_LO 4
`define AAM_K2_ARCH_BIT 3
`define AAM_K2_MODE_HI 2
`define AAM_K2_MODE_LO 0

// ============================================================
// codes
`define AAM_MODE_UNIDIR 3'h4
`define AAM_REQ_REVERSE 4'h2
`define AAM_REQ_SF_LO 4'hC
`define AAM_REQ_SF_HI 4'hD
`define AAM_PROT_CHAN 4'h0
`define AAM_LINE_WORK 1'b0
`define AAM_LINE_PROT 1'b1

// ============================================================
// counts
`define AAM_STABLE_FRAMES 3
`define AAM_UNSTABLE_FRAMES 12
`define AAM_CNT_W 32

`endif

/* rtl/aam_pkg.sv */
// ============================================================
// types shared by the protection alarm monitor files
// assumes: aam_defs.svh is on the include path
`include "aam_defs.svh"

package aam_pkg;

    typedef struct packed {
        logic bidir;           // bidirectional switching mode
        logic arch1to1;        // local architecture is 1:1 (else 1+1)
        logic stdIntl;         // local card set to the international_standard_variant
        logic peerCardStdIntl; // mate card of a two-card pair set to the international variant
        logic farStdIntl;      // far end reported on the international variant
        logic twoCard;         // two-card 1+1 pair
        logic revertive;       // revertive switching enabled
    } aam_cfg_t;

    typedef struct packed {
        logic los;
        logic lof;
        logic ais;
        logic berExcess;  // ber above the fixed failure limit
        logic berDegrade; // ber above the configured degrade threshold
    } aam_defect_t;

    typedef struct packed {
        logic stdMismatch;
        logic cardMissing;
        logic remoteSigFail;
        logic chanMismatch;
        logic invalidK1;
        logic protByteFail;
        logic farEndProtFail;
        logic archMismatch;
    } aam_alarm_t;

    typedef struct packed {
        logic apsOk;
        logic apsDeactivated;
    } aam_clear_t;

    typedef struct packed {
        logic initClrRevert;
        logic cantClrRevert;
        logic manualDone;
        logic manualFail;
        logic sdLoDone;
        logic sdLoFail;
    } aam_event_t;

    typedef enum logic {
        HOLD_NONE,
        HOLD_MANUAL
    } aam_hold_t;

endpackage

/* rtl/aam_kbyte_filter.sv */
// ============================================================
// stability filter for one received protection byte
// assumes: sample pulses once per received frame, same clock domain
`timescale 1ns/1ps
`include "aam_defs.svh"

module aam_kbyte_filter #(
    parameter int W = 8,
    parameter int STABLE_FRAMES = `AAM_STABLE_FRAMES,
    parameter int UNSTABLE_FRAMES = `AAM_UNSTABLE_FRAMES
) (
    input wire logic core_clk,      // system clock
    input wire logic srst,          // synchronous reset, active high
    input wire logic sample,        // new byte present this cycle
    input wire logic [W-1:0] byteIn, // received byte
    output logic [W-1:0] accepted,  // last byte seen on enough consecutive frames
    output logic unstable           // no acceptance for too many frames
);
    localparam int CW = $clog2(UNSTABLE_FRAMES + 1);

    logic [W-1:0] cand_reg, cand_next;
    logic [W-1:0] acc_reg, acc_next;
    logic [CW-1:0] match_reg, match_next;
    logic [CW-1:0] miss_reg, miss_next;
    logic uns_reg, uns_next;

    always_comb begin
        cand_next = cand_reg;
        acc_next = acc_reg;
        match_next = match_reg;
        miss_next = miss_reg;
        uns_next = uns_reg;
        if (sample) begin
            cand_next = byteIn;
            if (byteIn != cand_reg) begin
                match_next = CW'(1);
            end else if (match_reg != CW'(STABLE_FRAMES)) begin
                match_next = match_reg + 1'b1;
            end
            // saturated match keeps re-accepting, so a steady byte never ages out
            if (match_next == CW'(STABLE_FRAMES)) begin
                acc_next = byteIn;
                miss_next = '0;
                uns_next = 1'b0;
            end else if (miss_reg != CW'(UNSTABLE_FRAMES)) begin
                miss_next = miss_reg + 1'b1;
                if (miss_next == CW'(UNSTABLE_FRAMES)) begin
                    uns_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cand_reg <= '0;
            acc_reg <= '0;
            match_reg <= '0;
            miss_reg <= '0;
            uns_reg <= 1'b0;
        end else begin
            cand_reg <= cand_next;
            acc_reg <= acc_next;
            match_reg <= match_next;
            miss_reg <= miss_next;
            uns_reg <= uns_next;
        end
    end

    assign accepted = acc_reg;
    assign unstable = uns_reg;

endmodule

/* rtl/aam_alarm_monitor.sv */
// ============================================================
// protection alarm monitor for a redundant line pair: minor alarms,
// clear states, informational switch events and per-line error counts
// assumes: all inputs come from logic on core_clk; requests are pulses
//
// Notes on behaviour
// - error counts survive any line switchover; only statsClear or srst resets them
// - alarms detected on both lines, error counts kept for the active line
// - no statistics accumulate for the standby line
// - two-card pair with differing standards raises standard mismatch
// - missing front or rear card raises card missing
// - line up and alarm free shows ok; line down shows deactivated
// - faulty far-end signalling in received K2 raises remote signal failure
// - unstable protection byte exchange raises protection byte failure in any mode
// - far end signalling failure on protection channel raises far-end failure
// - far end standard or architecture differing raises architecture mismatch
// - event on initialisation, clear switch or revert switch
// - event when a clear switch cannot be done; a revert that cannot be made raises no event
// - events for manual switch done and manual switch refused
// - low priority degrade switches automatically and reports it
// - event when a degrade switch cannot be made
// - signal failure is los, lof, ais or ber over limit; switches automatically
`timescale 1ns/1ps
`include "aam_defs.svh"

module aam_alarm_monitor import aam_pkg::*; #(
    parameter int CNT_W = `AAM_CNT_W,
    parameter int STABLE_FRAMES = `AAM_STABLE_FRAMES,
    parameter int UNSTABLE_FRAMES = `AAM_UNSTABLE_FRAMES
) (
    input wire logic core_clk,                // system clock, 100 MHz
    input wire logic srst,                    // synchronous reset, active high
    input wire logic apsEnable,               // protection configured and running
    input wire aam_cfg_t cfg,                 // static configuration
    input wire logic lineUp,                  // protected line is up
    input wire logic frontPresent,            // front card detected
    input wire logic rearPresent,             // rear card detected
    input wire logic [7:0] rxK1,              // received K1
    input wire logic [7:0] rxK2,              // received K2
    input wire logic rxKValid,                // received bytes valid, once a frame
    input wire logic [7:0] txK1,              // transmitted K1
    input wire aam_defect_t [1:0] defect,     // defects per line, index 0 working
    input wire logic [1:0] errPulse,          // one error seen per line
    input wire logic statsClear,              // software clear of error counts
    input wire logic manualReq,               // manual switch to the other line
    input wire logic clearReq,                // clear switch request
    output aam_alarm_t alarm,                 // minor alarms, levels
    output aam_clear_t clearState,            // clear states, levels
    output aam_event_t apsEvent,              // informational events, pulses
    output logic activeLine,                  // 0 working, 1 protection
    output logic [1:0] lineFail,              // signal failure per line
    output logic [CNT_W-1:0] errCntWork,      // error count, working line
    output logic [CNT_W-1:0] errCntProt       // error count, protection line
);

    // ============================================================
    // received byte stability
    logic [7:0] accK1, accK2;
    logic unsK1, unsK2;

    aam_kbyte_filter #(
        .W(8),
        .STABLE_FRAMES(STABLE_FRAMES),
        .UNSTABLE_FRAMES(UNSTABLE_FRAMES)
    ) u_filt_k1 (
        .core_clk(core_clk),
        .srst(srst),
        .sample(rxKValid),
        .byteIn(rxK1),
        .accepted(accK1),
        .unstable(unsK1)
    );

    aam_kbyte_filter #(
        .W(8),
        .STABLE_FRAMES(STABLE_FRAMES),
        .UNSTABLE_FRAMES(UNSTABLE_FRAMES)
    ) u_filt_k2 (
        .core_clk(core_clk),
        .srst(srst),
        .sample(rxKValid),
        .byteIn(rxK2),
        .accepted(accK2),
        .unstable(unsK2)
    );

    // ============================================================
    // line conditions
    logic [1:0] sf, sd;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sf[i] = defect[i].los | defect[i].lof | defect[i].ais | defect[i].berExcess;
            sd[i] = defect[i].berDegrade;
        end
    end

    // ============================================================
    // alarms and clear states
    aam_alarm_t alarm_reg, alarm_next;
    aam_clear_t clear_reg, clear_next;
    logic [1:0] lineFail_reg;
    logic [3:0] rxReq, txReq;

    assign rxReq = accK1[`AAM_K1_REQ_HI:`AAM_K1_REQ_LO];
    assign txReq = txK1[`AAM_K1_REQ_HI:`AAM_K1_REQ_LO];

    always_comb begin
        alarm_next.stdMismatch = cfg.twoCard & (cfg.stdIntl ^ cfg.peerCardStdIntl);
        alarm_next.cardMissing = ~frontPresent | ~rearPresent;
        // mode codes below unidirectional carry no valid far-end signalling
        alarm_next.remoteSigFail = accK2[`AAM_K2_MODE_HI:`AAM_K2_MODE_LO] < `AAM_MODE_UNIDIR;
        alarm_next.chanMismatch = cfg.bidir &
            (accK2[`AAM_K2_CHAN_HI:`AAM_K2_CHAN_LO] != txK1[`AAM_K1_CHAN_HI:`AAM_K1_CHAN_LO]);
        alarm_next.invalidK1 = cfg.bidir & (rxReq != `AAM_REQ_REVERSE) & (rxReq < txReq);
        alarm_next.protByteFail = unsK1 | unsK2 | alarm_next.invalidK1;
        alarm_next.farEndProtFail = ((rxReq == `AAM_REQ_SF_LO) | (rxReq == `AAM_REQ_SF_HI)) &
            (accK1[`AAM_K1_CHAN_HI:`AAM_K1_CHAN_LO] == `AAM_PROT_CHAN);
        alarm_next.archMismatch = (accK2[`AAM_K2_ARCH_BIT] ^ cfg.arch1to1) |
            (cfg.farStdIntl ^ cfg.stdIntl);
        // conditions are re-evaluated each cycle, so alarms drop as soon as the cause goes
        clear_next.apsOk = lineUp & ~(|alarm_next) & ~(|sf);
        clear_next.apsDeactivated = ~lineUp;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            alarm_reg <= '0;
            clear_reg <= '0;
            lineFail_reg <= '0;
        end else begin
            alarm_reg <= alarm_next;
            clear_reg <= clear_next;
            lineFail_reg <= sf;
        end
    end

    // ============================================================
    // line selection and switch events
    logic act_reg, act_next;
    logic enabled_reg, enabled_next;
    logic sdSeen_reg, sdSeen_next;
    aam_hold_t hold_reg, hold_next;
    aam_event_t event_reg, event_next;
    logic other;

    assign other = ~act_reg;

    always_comb begin
        act_next = act_reg;
        hold_next = hold_reg;
        event_next = '0;
        enabled_next = apsEnable;
        // degrade acts on its rising edge only, so a refused switch reports once
        sdSeen_next = sd[act_reg];
        if (!apsEnable) begin
            act_next = `AAM_LINE_WORK;
            hold_next = HOLD_NONE;
        end else if (!enabled_reg) begin
            act_next = `AAM_LINE_WORK;
            hold_next = HOLD_NONE;
            event_next.initClrRevert = 1'b1;
        end else if (sf[act_reg] && !sf[other]) begin
            act_next = other;
        end else if (manualReq) begin
            if (!sf[other]) begin
                act_next = other;
                hold_next = HOLD_MANUAL;
                event_next.manualDone = 1'b1;
            end else begin
                event_next.manualFail = 1'b1;
            end
        end else if (clearReq) begin
            hold_next = HOLD_NONE;
            if (act_reg == `AAM_LINE_WORK) begin
                event_next.initClrRevert = 1'b1;
            end else if (!sf[`AAM_LINE_WORK] && !sd[`AAM_LINE_WORK]) begin
                act_next = `AAM_LINE_WORK;
                event_next.initClrRevert = 1'b1;
            end else begin
                event_next.cantClrRevert = 1'b1;
            end
        end else if (sd[act_reg] && !sdSeen_reg) begin
            if (!sf[other] && !sd[other]) begin
                act_next = other;
                event_next.sdLoDone = 1'b1;
            end else begin
                event_next.sdLoFail = 1'b1;
            end
        end else if (cfg.revertive && hold_reg == HOLD_NONE && act_reg == `AAM_LINE_PROT &&
                     !sf[`AAM_LINE_WORK] && !sd[`AAM_LINE_WORK]) begin
            act_next = `AAM_LINE_WORK;
            event_next.initClrRevert = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            act_reg <= `AAM_LINE_WORK;
            enabled_reg <= 1'b0;
            sdSeen_reg <= 1'b0;
            hold_reg <= HOLD_NONE;
            event_reg <= '0;
        end else begin
            act_reg <= act_next;
            enabled_reg <= enabled_next;
            sdSeen_reg <= sdSeen_next;
            hold_reg <= hold_next;
            event_reg <= event_next;
        end
    end

    // ============================================================
    // error statistics, active line only
    logic [1:0][CNT_W-1:0] cnt_reg, cnt_next;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cnt_next[i] = cnt_reg[i];
            // no reaction to the active line changing: counts are kept across switchover
            if (statsClear) begin
                cnt_next[i] = '0;
            end else if (errPulse[i] && (act_reg == i[0]) && !(&cnt_reg[i])) begin
                cnt_next[i] = cnt_reg[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign alarm = alarm_reg;
    assign clearState = clear_reg;
    assign apsEvent = event_reg;
    assign activeLine = act_reg;
    assign lineFail = lineFail_reg;
    assign errCntWork = cnt_reg[0];
    assign errCntProt = cnt_reg[1];

    // ============================================================
    // checks
    a_std_mismatch: assert property (@(posedge core_clk) disable iff (srst)
        cfg.twoCard && (cfg.stdIntl != cfg.peerCardStdIntl) |=> alarm.stdMismatch)
        else $error("standard mismatch not raised");
    a_card_missing: assert property (@(posedge core_clk) disable iff (srst)
        (!frontPresent || !rearPresent) |=> alarm.cardMissing)
        else $error("card missing not raised");
    a_line_down: assert property (@(posedge core_clk) disable iff (srst)
        !lineUp |=> clearState.apsDeactivated && !clearState.apsOk)
        else $error("deactivated state wrong while line down");
    a_chan_unidir: assert property (@(posedge core_clk) disable iff (srst)
        !cfg.bidir |=> !alarm.chanMismatch && !alarm.invalidK1)
        else $error("bidirectional alarm outside bidirectional mode");
    a_psb_unstable: assert property (@(posedge core_clk) disable iff (srst)
        (unsK1 || unsK2) |=> alarm.protByteFail)
        else $error("unstable bytes without byte failure alarm");
    a_standby_stats: assert property (@(posedge core_clk) disable iff (srst)
        !statsClear && activeLine == `AAM_LINE_WORK |=> $stable(errCntProt))
        else $error("standby line counted errors");
    a_stats_kept: assert property (@(posedge core_clk) disable iff (srst)
        !statsClear ##1 $changed(activeLine) |-> errCntWork >= $past(errCntWork))
        else $error("counts lost on switchover");
    a_event_single: assert property (@(posedge core_clk) disable iff (srst)
        $onehot0(apsEvent))
        else $error("more than one event at once");
    a_manual_moves: assert property (@(posedge core_clk) disable iff (srst)
        apsEvent.manualDone |-> activeLine != $past(activeLine))
        else $error("manual switch reported without a switch");
    a_degrade_moves: assert property (@(posedge core_clk) disable iff (srst)
        apsEvent.sdLoDone |-> activeLine != $past(activeLine) && !lineFail[activeLine])
        else $error("degrade switch reported without a switch");
    a_far_end_fail: assert property (@(posedge core_clk) disable iff (srst)
        (accK1[`AAM_K1_REQ_HI:`AAM_K1_REQ_LO] == `AAM_REQ_SF_HI) &&
        (accK1[`AAM_K1_CHAN_HI:`AAM_K1_CHAN_LO] == `AAM_PROT_CHAN) |=> alarm.farEndProtFail)
        else $error("far end protection failure not raised");

endmodule

/* verification/aam_far_end.sv */
// far-end terminal model: sends one received K1/K2 pair per frame
// assumes: bench sets the bytes to send; frames are four core_clk cycles apart
`timescale 1ns/1ps

module aam_far_end (
    input wire logic core_clk,     // system clock
    input wire logic srst,         // synchronous reset, active high
    input wire logic [7:0] sendK1, // K1 the far end transmits
    input wire logic [7:0] sendK2, // K2 the far end transmits
    output logic [7:0] rxK1,       // K1 as seen by the monitor
    output logic [7:0] rxK2,       // K2 as seen by the monitor
    output logic rxKValid          // one-cycle frame strobe
);
    logic [1:0] phase;

    initial begin
        phase = 2'h0;
        rxK1 = 8'h00;
        rxK2 = 8'h00;
        rxKValid = 1'b0;
    end

    // ============================================================
    // frame generator
    // between frames the bytes flip every cycle so a stray sample is never mistaken for a stable one
    always @(negedge core_clk) begin
        phase <= srst ? 2'h0 : phase + 2'h1;
        rxKValid <= !srst && phase == 2'h3;
        if (!srst && phase == 2'h3) begin
            rxK1 <= sendK1;
            rxK2 <= sendK2;
        end else begin
            rxK1 <= ~rxK1;
            rxK2 <= ~rxK2;
        end
    end
endmodule

/* verification/aam_alarm_monitor_test.sv */
// self-checking bench for the protection alarm monitor
// assumes: inputs change on the falling edge; counts shrunk to 4 bits to reach saturation
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
    begin \
        samplesChecked++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end

module aam_alarm_monitor_test import aam_pkg::*; ();
    localparam logic [5:0] EV_INIT = 6'h20;
    localparam logic [5:0] EV_CANT = 6'h10;
    localparam logic [5:0] EV_MD = 6'h08;
    localparam logic [5:0] EV_MF = 6'h04;
    localparam logic [5:0] EV_SDD = 6'h02;
    localparam logic [5:0] EV_SDF = 6'h01;
    logic core_clk = 1'b0;
    logic srst, apsEnable, lineUp, frontPresent, rearPresent, rxKValid, statsClear, manualReq, clearReq;
    aam_cfg_t cfg;
    logic [7:0] rxK1, rxK2, txK1, sendK1, sendK2;
    aam_defect_t [1:0] defect;
    logic [1:0] errPulse, lineFail;
    aam_alarm_t alarm;
    aam_clear_t clearState;
    aam_event_t apsEvent;
    logic activeLine;
    logic [3:0] errCntWork, errCntProt;
    int fails = 0;
    int samplesChecked = 0;

    always #5 core_clk = ~core_clk;

    aam_alarm_monitor #(.CNT_W(4)) aam_alarm_monitor_i (.core_clk(core_clk), .srst(srst), .apsEnable(apsEnable),
        .cfg(cfg), .lineUp(lineUp), .frontPresent(frontPresent), .rearPresent(rearPresent), .rxK1(rxK1),
        .rxK2(rxK2), .rxKValid(rxKValid), .txK1(txK1), .defect(defect), .errPulse(errPulse),
        .statsClear(statsClear), .manualReq(manualReq), .clearReq(clearReq), .alarm(alarm),
        .clearState(clearState), .apsEvent(apsEvent), .activeLine(activeLine), .lineFail(lineFail),
        .errCntWork(errCntWork), .errCntProt(errCntProt));
    aam_far_end aam_far_end_i (.core_clk(core_clk), .srst(srst), .sendK1(sendK1), .sendK2(sendK2),
        .rxK1(rxK1), .rxK2(rxK2), .rxKValid(rxKValid));

    // ============================================================
    // shared tasks
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic lv(input logic [7:0] a, input logic [1:0] c);
        step(2);
        `CHK("alarm", a, alarm);
        `CHK("clearState", c, clearState);
    endtask

    // long wait covers six frames: three to settle plus margin for phase slip
    task automatic kc(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] tx, input logic [7:0] a);
        sendK1 = k1;
        sendK2 = k2;
        txK1 = tx;
        step(24);
        `CHK("alarm", a, alarm);
    endtask

    task automatic act(input logic m, input logic c, input logic [5:0] ev, input logic ln);
        manualReq = m;
        clearReq = c;
        step(1);
        manualReq = 1'b0;
        clearReq = 1'b0;
        `CHK("apsEvent", ev, apsEvent);
        `CHK("activeLine", ln, activeLine);
        step(1);
        `CHK("apsEvent", 6'h00, apsEvent);
    endtask

    task automatic tallyAndFinish;
        $display("comparisons %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic testInit;
        `CHK("errCntWork", 4'h0, errCntWork);
        `CHK("apsEvent", 6'h00, apsEvent);
        apsEnable = 1'b1;
        step(1);
        `CHK("apsEvent", EV_INIT, apsEvent);
        step(22);
        lv(8'h00, 2'b10);
    endtask

    task automatic testLevels;
        cfg.twoCard = 1'b1;
        cfg.peerCardStdIntl = 1'b1;
        lv(8'h80, 2'b00);
        cfg.peerCardStdIntl = 1'b0;
        lv(8'h00, 2'b10);
        cfg.twoCard = 1'b0;
        cfg.farStdIntl = 1'b1;
        lv(8'h01, 2'b00);
        cfg.farStdIntl = 1'b0;
        frontPresent = 1'b0;
        lv(8'h40, 2'b00);
        frontPresent = 1'b1;
        rearPresent = 1'b0;
        lv(8'h40, 2'b00);
        rearPresent = 1'b1;
        lineUp = 1'b0;
        lv(8'h00, 2'b01);
        lineUp = 1'b1;
        lv(8'h00, 2'b10);
    endtask

    task automatic testKBytes;
        kc(8'h00, 8'h03, 8'h00, 8'h20);
        kc(8'h00, 8'h04, 8'h00, 8'h00);
        kc(8'h00, 8'h15, 8'h00, 8'h10);
        cfg.bidir = 1'b0;
        lv(8'h00, 2'b10);
        cfg.bidir = 1'b1;
        kc(8'h10, 8'h05, 8'h30, 8'h0C);
        kc(8'h20, 8'h05, 8'h30, 8'h00);
        kc(8'hC0, 8'h05, 8'h00, 8'h02);
        kc(8'hD0, 8'h05, 8'h00, 8'h02);
        kc(8'h00, 8'h0D, 8'h00, 8'h01);
        kc(8'h00, 8'h05, 8'h00, 8'h00);
        // a changing byte every frame never settles
        for (int i = 0; i < 16; i++) begin
            sendK1 = i[0] ? 8'h01 : 8'h00;
            step(4);
        end
        `CHK("alarm", 8'h04, alarm);
        kc(8'h00, 8'h05, 8'h00, 8'h00);
    endtask

    task automatic testSwitch;
        act(1'b1, 1'b0, EV_MD, 1'b1);
        act(1'b1, 1'b0, EV_MD, 1'b0);
        act(1'b0, 1'b1, EV_INIT, 1'b0);
        for (int k = 0; k < 4; k++) begin
            defect[0] = aam_defect_t'(5'h10 >> k);
            act(1'b0, 1'b0, 6'h00, 1'b1);
            `CHK("lineFail", 2'b01, lineFail);
            act(1'b1, 1'b0, EV_MF, 1'b1);
            act(1'b0, 1'b1, EV_CANT, 1'b1);
            defect[0] = '0;
            act(1'b0, 1'b1, EV_INIT, 1'b0);
        end
        cfg.revertive = 1'b1;
        defect[0].los = 1'b1;
        act(1'b0, 1'b0, 6'h00, 1'b1);
        defect[0] = '0;
        act(1'b0, 1'b0, EV_INIT, 1'b0);
        cfg.revertive = 1'b0;
    endtask

    task automatic testDegrade;
        defect[0].berDegrade = 1'b1;
        act(1'b0, 1'b0, EV_SDD, 1'b1);
        act(1'b0, 1'b1, EV_CANT, 1'b1);
        defect[0].berDegrade = 1'b0;
        act(1'b0, 1'b1, EV_INIT, 1'b0);
        defect[1].los = 1'b1;
        step(1);
        defect[0].berDegrade = 1'b1;
        act(1'b0, 1'b0, EV_SDF, 1'b0);
        defect = '0;
        step(2);
    endtask

    task automatic testCounts;
        errPulse = 2'b11;
        step(5);
        errPulse = 2'b00;
        step(1);
        `CHK("errCntWork", 4'h5, errCntWork);
        `CHK("errCntProt", 4'h0, errCntProt);
        act(1'b1, 1'b0, EV_MD, 1'b1);
        `CHK("errCntWork", 4'h5, errCntWork);
        errPulse = 2'b11;
        step(20);
        errPulse = 2'b00;
        step(1);
        `CHK("errCntWork", 4'h5, errCntWork);
        `CHK("errCntProt", 4'hF, errCntProt);
        act(1'b0, 1'b1, EV_INIT, 1'b0);
        `CHK("errCntProt", 4'hF, errCntProt);
        statsClear = 1'b1;
        errPulse = 2'b11;
        step(1);
        statsClear = 1'b0;
        errPulse = 2'b00;
        step(1);
        `CHK("errCntWork", 4'h0, errCntWork);
        `CHK("errCntProt", 4'h0, errCntProt);
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        srst = 1'b1;
        apsEnable = 1'b0;
        cfg = '0;
        cfg.bidir = 1'b1;
        lineUp = 1'b1;
        frontPresent = 1'b1;
        rearPresent = 1'b1;
        txK1 = 8'h00;
        sendK1 = 8'h00;
        sendK2 = 8'h05;
        defect = '0;
        errPulse = 2'b00;
        statsClear = 1'b0;
        manualReq = 1'b0;
        clearReq = 1'b0;
        step(6);
        srst = 1'b0;
        testInit();
        testLevels();
        testKBytes();
        testSwitch();
        testDegrade();
        testCounts();
        tallyAndFinish();
    end

    // the whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        tallyAndFinish();
    end
endmodule
